// *** jid_pkg.sv ***
`default_nettype none
package jid_pkg;

   ////////////////////////////////////////////////////////////////////////
   // instruction register
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
   localparam logic [IR_W-1:0] OP_HIGHZ = 4'h4;
   localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
   // capture pattern, two low bits fixed at 01
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;

   ////////////////////////////////////////////////////////////////////////
   // identification word; field values are arbitrary
   localparam int ID_W = 32;
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART = 16'h5A3C;
   localparam logic [10:0] ID_MAKER = 11'h2D5;
   localparam logic [ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER,
                                          1'b1};

   ////////////////////////////////////////////////////////////////////////
   // boundary cells: [7:0] inputs, [15:8] outputs, [23:16] enables
   localparam int IO_W = 8;
   localparam int BSR_W = 3 * IO_W;
   localparam int BSR_IN_LSB = 0;
   localparam int BSR_OUT_LSB = IO_W;
   localparam int BSR_OE_LSB = 2 * IO_W;
   localparam logic [BSR_W-1:0] BSR_RESET = 24'h000000;
   localparam logic [IO_W-1:0] IO_RESET = 8'h00;
   localparam logic [IO_W-1:0] IO_ALL_ON = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } jid_tap_t;

   typedef enum logic [1:0] {DR_BSR, DR_ID, DR_BYP} jid_dr_sel_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jid_pins_t;

   typedef struct packed {
      logic [IO_W-1:0] oe;
      logic [IO_W-1:0] val;
   } jid_io_t;

endpackage
`default_nettype wire

// *** jid_sync.sv ***
`default_nettype none
module jid_sync
   import jid_pkg::*;
#(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // asynchronous level in, synchronous level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } jid_sync_st_t;

   jid_sync_st_t st_reg;
   jid_sync_st_t st_next;

   // meta feeds only the second stage
   always_comb
   begin
      st_next.meta = d;
      st_next.q = st_reg.meta;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.q;

endmodule // jid_sync
`default_nettype wire

// *** jid_bsr.sv ***
`default_nettype none
module jid_bsr
   import jid_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // controls, each a one-cycle pulse
   input wire logic cap_en,
   input wire logic shift_en,
   input wire logic upd_en,
   // serial and parallel data
   input wire logic tdi,
   input wire logic [BSR_W-1:0] par_in,
   output logic so,
   output logic [BSR_W-1:0] upd_q
);

   typedef struct packed {
      logic [BSR_W-1:0] sr;
      logic [BSR_W-1:0] upd;
   } jid_bsr_st_t;

   jid_bsr_st_t st_reg;
   jid_bsr_st_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (cap_en)
      begin
         st_next.sr = par_in;
      end
      else if (shift_en)
      begin
         st_next.sr = {tdi, st_reg.sr[BSR_W-1:1]};
      end
      // update stage only moves on update, so preloaded data survives
      if (upd_en)
      begin
         st_next.upd = st_reg.sr;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_reg.sr <= BSR_RESET;
         st_reg.upd <= BSR_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign so = st_reg.sr[0];
   assign upd_q = st_reg.upd;

   a_upd_hold:
      assert property (@(posedge clk_sys) disable iff (srst)
         !upd_en |=> upd_q == $past(upd_q))
      else $error("update stage changed without update");

   a_shift_step:
      assert property (@(posedge clk_sys) disable iff (srst)
         (shift_en && !cap_en) |=> so == $past(st_reg.sr[1]))
      else $error("boundary shift did not advance");

endmodule // jid_bsr
`default_nettype wire

// *** jid_top.sv ***
// Function
// - EXTEST enters boundary-test mode with the boundary register on TDI-TDO.
// - under EXTEST the boundary cells drive the outputs and capture inputs.
// - IDCODE keeps the device functional and puts the ID register in path.
// - the ID register is a 32-bit shift register of maker, part, version.
// - scanning the ID register leaves functional behaviour untouched.
// - IDCODE is current after power-up, TRST and any Test-Logic-Reset.
// - SAMPLE/PRELOAD stays functional, selects and snapshots the boundary.
// - values preloaded into the boundary register are kept for EXTEST.
// - the high-impedance instruction disables every output.
// - high-impedance shifts through bypass without touching the boundary register.
// - BYPASS stays functional and shifts through a single stage.
// - the instruction register is four bits wide.
// - codes 0,1,2,4,F select EXTEST, SAMPLE, IDCODE, HIGHZ, BYPASS.
// - the bypass stage loads zero at the rising TCK edge in Capture-DR.
// - the ID word is 1 in bit 0, maker 11, part 16, version 4 bits.
`default_nettype none
module jid_top
   import jid_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   // core side
   input wire logic [IO_W-1:0] core_out,
   input wire logic [IO_W-1:0] core_oe,
   output logic [IO_W-1:0] core_in,
   output logic ext_mode,
   // device pins
   input wire logic [IO_W-1:0] pin_in,
   output logic [IO_W-1:0] pin_out,
   output logic [IO_W-1:0] pin_oe
);

   typedef struct packed {
      logic tck_d;
      jid_tap_t tap;
      logic [IR_W-1:0] ir_sr;
      logic [IR_W-1:0] ir;
      logic [ID_W-1:0] id_sr;
      logic byp;
      logic tdo;
      logic tdo_oe;
      jid_io_t pin;
      logic [IO_W-1:0] core_in;
      logic ext_mode;
   } jid_top_st_t;

   localparam jid_top_st_t ST_RST = '{
      tck_d: 1'b0, tap: TAP_TLR, ir_sr: IR_CAPTURE, ir: IR_RESET,
      id_sr: ID_WORD, byp: 1'b0, tdo: 1'b0, tdo_oe: 1'b0,
      pin: '{oe: IO_RESET, val: IO_RESET}, core_in: IO_RESET,
      ext_mode: 1'b0};

   jid_top_st_t st_reg;
   jid_top_st_t st_next;
   jid_pins_t pins_raw;
   jid_pins_t pins_s;
   logic [IO_W-1:0] pin_in_s;
   logic tck_rise;
   logic tck_fall;
   jid_dr_sel_t dr_sel;
   logic bsr_cap;
   logic bsr_shift;
   logic bsr_upd_en;
   logic bsr_so;
   logic [BSR_W-1:0] bsr_upd;
   logic dr_out;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; tck is sampled, not used as a clock

   assign pins_raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

   jid_sync #(.W($bits(jid_pins_t))) u_sync_pins (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(pins_raw),
      .q(pins_s)
   );

   jid_sync #(.W(IO_W)) u_sync_io (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(pin_in),
      .q(pin_in_s)
   );

   assign tck_rise = pins_s.tck & ~st_reg.tck_d;
   assign tck_fall = ~pins_s.tck & st_reg.tck_d;

   ////////////////////////////////////////////////////////////////////////
   // tap sequencing

   function automatic jid_tap_t tap_next(jid_tap_t s, logic m);
      case (s)
         TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
         TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         default: tap_next = TAP_TLR;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // instruction decode and data register path

   always_comb
   begin
      case (st_reg.ir)
         OP_EXTEST, OP_SAMPLE: dr_sel = DR_BSR;
         OP_IDCODE: dr_sel = DR_ID;
         default: dr_sel = DR_BYP;
      endcase
   end

   always_comb
   begin
      case (dr_sel)
         DR_BSR: dr_out = bsr_so;
         DR_ID: dr_out = st_reg.id_sr[0];
         default: dr_out = st_reg.byp;
      endcase
   end

   assign bsr_cap = tck_rise && st_reg.tap == TAP_CAP_DR && dr_sel == DR_BSR;
   assign bsr_shift = tck_rise && st_reg.tap == TAP_SH_DR && dr_sel == DR_BSR;
   assign bsr_upd_en = tck_fall && st_reg.tap == TAP_UPD_DR &&
                       dr_sel == DR_BSR;

   // snapshot of what enters and leaves, in any boundary instruction
   jid_bsr u_bsr (
      .clk_sys(clk_sys),
      .srst(srst),
      .cap_en(bsr_cap),
      .shift_en(bsr_shift),
      .upd_en(bsr_upd_en),
      .tdi(pins_s.tdi),
      .par_in({core_oe, core_out, pin_in_s}),
      .so(bsr_so),
      .upd_q(bsr_upd)
   );

   ////////////////////////////////////////////////////////////////////////
   // state update

   always_comb
   begin
      st_next = st_reg;
      st_next.tck_d = pins_s.tck;
      if (tck_rise)
      begin
         st_next.tap = tap_next(st_reg.tap, pins_s.tms);
         case (st_reg.tap)
            TAP_CAP_IR: st_next.ir_sr = IR_CAPTURE;
            TAP_SH_IR: st_next.ir_sr = {pins_s.tdi, st_reg.ir_sr[IR_W-1:1]};
            TAP_CAP_DR:
            begin
               if (dr_sel == DR_ID)
               begin
                  st_next.id_sr = ID_WORD;
               end
               if (dr_sel == DR_BYP)
               begin
                  st_next.byp = 1'b0;
               end
            end
            TAP_SH_DR:
            begin
               if (dr_sel == DR_ID)
               begin
                  st_next.id_sr = {pins_s.tdi, st_reg.id_sr[ID_W-1:1]};
               end
               if (dr_sel == DR_BYP)
               begin
                  st_next.byp = pins_s.tdi;
               end
            end
            default:
            begin
               st_next.byp = st_reg.byp;
            end
         endcase
      end
      // tdo moves on the falling edge so the far end samples it stable
      if (tck_fall)
      begin
         st_next.tdo_oe = 1'b0;
         if (st_reg.tap == TAP_SH_IR)
         begin
            st_next.tdo = st_reg.ir_sr[0];
            st_next.tdo_oe = 1'b1;
         end
         else if (st_reg.tap == TAP_SH_DR)
         begin
            st_next.tdo = dr_out;
            st_next.tdo_oe = 1'b1;
         end
         if (st_reg.tap == TAP_UPD_IR)
         begin
            st_next.ir = st_reg.ir_sr;
         end
      end
      if (st_reg.tap == TAP_TLR)
      begin
         st_next.ir = IR_RESET;
      end
      if (!pins_s.trst_n)
      begin
         st_next.tap = TAP_TLR;
         st_next.ir = IR_RESET;
         st_next.tdo_oe = 1'b0;
      end
      // pin drive follows the current instruction only
      case (st_reg.ir)
         OP_EXTEST:
         begin
            st_next.pin.val = bsr_upd[BSR_OUT_LSB +: IO_W];
            st_next.pin.oe = bsr_upd[BSR_OE_LSB +: IO_W];
         end
         OP_HIGHZ:
         begin
            st_next.pin.val = core_out;
            st_next.pin.oe = IO_RESET;
         end
         default:
         begin
            st_next.pin.val = core_out;
            st_next.pin.oe = core_oe;
         end
      endcase
      st_next.ext_mode = st_reg.ir == OP_EXTEST;
      st_next.core_in = pin_in_s;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_reg <= ST_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign tdo = st_reg.tdo;
   assign tdo_oe = st_reg.tdo_oe;
   assign core_in = st_reg.core_in;
   assign ext_mode = st_reg.ext_mode;
   assign pin_out = st_reg.pin.val;
   assign pin_oe = st_reg.pin.oe;

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_extest_drive:
      assert property (@(posedge clk_sys) disable iff (srst)
         st_reg.ir == OP_EXTEST |=>
         pin_out == $past(bsr_upd[BSR_OUT_LSB +: IO_W]) &&
         pin_oe == $past(bsr_upd[BSR_OE_LSB +: IO_W]) && ext_mode)
      else $error("extest pins not driven from boundary cells");

   a_highz_float:
      assert property (@(posedge clk_sys) disable iff (srst)
         st_reg.ir == OP_HIGHZ ##1 st_reg.ir == OP_HIGHZ |-> pin_oe == 8'h00)
      else $error("output enabled under high impedance");

   a_highz_bypass:
      assert property (@(posedge clk_sys) disable iff (srst)
         st_reg.ir == OP_HIGHZ |-> dr_sel == DR_BYP && !bsr_shift)
      else $error("high impedance not on bypass");

   a_func_pass:
      assert property (@(posedge clk_sys) disable iff (srst)
         (st_reg.ir != OP_EXTEST && st_reg.ir != OP_HIGHZ) |=>
         pin_out == $past(core_out) && pin_oe == $past(core_oe))
      else $error("functional outputs disturbed");

   a_trst_idcode:
      assert property (@(posedge clk_sys) disable iff (srst)
         !pins_s.trst_n |=> st_reg.ir == OP_IDCODE && st_reg.tap == TAP_TLR)
      else $error("test reset did not select identification");

   a_decode_map:
      assert property (@(posedge clk_sys) disable iff (srst)
         (st_reg.ir == OP_SAMPLE |-> dr_sel == DR_BSR) and
         (st_reg.ir == OP_IDCODE |-> dr_sel == DR_ID) and
         (st_reg.ir == OP_BYPASS |-> dr_sel == DR_BYP))
      else $error("instruction decode mismatch");

   a_bypass_zero:
      assert property (@(posedge clk_sys) disable iff (srst)
         tck_rise && st_reg.tap == TAP_CAP_DR && dr_sel == DR_BYP &&
         pins_s.trst_n |=> st_reg.byp == 1'b0)
      else $error("bypass stage did not capture zero");

   a_id_capture:
      assert property (@(posedge clk_sys) disable iff (srst)
         tck_rise && st_reg.tap == TAP_CAP_DR && dr_sel == DR_ID |=>
         st_reg.id_sr[0] == 1'b1 && st_reg.id_sr == ID_WORD)
      else $error("identification word not captured");

   a_tdo_shift:
      assert property (@(posedge clk_sys) disable iff (srst)
         tck_fall && st_reg.tap == TAP_SH_DR && dr_sel == DR_BYP &&
         pins_s.trst_n |=> tdo == $past(st_reg.byp) && tdo_oe)
      else $error("bypass bit not presented on tdo");

endmodule // jid_top
`default_nettype wire

// *** jid_ctrl_model.sv ***
`default_nettype none
module jid_ctrl_model
(
   // test port pins toward the device
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   output var logic trst_n,
   // serial answer
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // one tck period; tms/tdi move only while tck is low, 40 ns before the rise
   // tdo is read mid-high, before the next fall can move it
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #40;
      tck = 1'b1;
      #20;
      q = tdo;
      #20;
      tck = 1'b0;
   endtask

   // five ones reach test-logic-reset from anywhere, then idle
   task automatic reset_tap();
      logic q;
      for (int i = 0; i < 5; i++)
         step(1'b1, i[0], q);
      step(1'b0, 1'b1, q);
   endtask

   // 60 ns low, 60 ns recovery, then idle
   task automatic pulse_trst();
      logic q;
      trst_n = 1'b0;
      #60;
      trst_n = 1'b1;
      #60;
      step(1'b0, 1'b0, q);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scans start and end in run-test-idle, lsb first
   task automatic load_ir(input logic [3:0] code);
      logic q;
      step(1'b1, 1'b0, q);
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < 4; i++)
         step(i == 3, code[i], q);
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b1, q);
   endtask

   task automatic scan_dr(input int n, input logic [31:0] din,
                          output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule // jid_ctrl_model
`default_nettype wire

// *** jtag_instruction_decode_tb.sv ***
`default_nettype none
module jtag_instruction_decode_tb;
   import jid_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [IR_W-1:0] code;
      jid_dr_sel_t sel;
      logic ext;
      logic hiz;
   } jid_row_t;

   localparam logic [31:0] DIN = 32'hC3A596E1;
   localparam logic [31:0] PRE = 32'h00E74B;

   logic clk_sys, srst, tck, tms, tdi, trst_n, tdo, tdo_oe, ext_mode;
   logic [IO_W-1:0] core_out, core_oe, core_in, pin_in, pin_out, pin_oe;
   logic [31:0] dout, exp_v;
   int err_total = 0;
   int check_count = 0;
   jid_row_t rows [8] = '{
      '{OP_EXTEST, DR_BSR, 1'b1, 1'b0}, '{OP_SAMPLE, DR_BSR, 1'b0, 1'b0},
      '{OP_IDCODE, DR_ID, 1'b0, 1'b0}, '{OP_HIGHZ, DR_BYP, 1'b0, 1'b1},
      '{OP_BYPASS, DR_BYP, 1'b0, 1'b0}, '{4'h3, DR_BYP, 1'b0, 1'b0},
      '{4'h7, DR_BYP, 1'b0, 1'b0}, '{4'hE, DR_BYP, 1'b0, 1'b0}};

   jid_top dut_u (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
      .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
      .ext_mode(ext_mode), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe));

   jid_ctrl_model ctrl_u (.tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .tdo(tdo));

   initial
   begin
      clk_sys = 1'b0;
      forever
         #5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
                  what, seen, exp);
      end
   endtask

   task automatic set_io(input logic [7:0] co, input logic [7:0] ce,
                         input logic [7:0] pi);
      @(posedge clk_sys);
      #1;
      core_out = co;
      core_oe = ce;
      pin_in = pi;
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // a hang costs a mismatch and still reaches the verdict
   initial
   begin
      #500000;
      err_total++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      core_out = 8'h00;
      core_oe = 8'h00;
      pin_in = 8'h00;
      repeat (10) @(posedge clk_sys);
      #1 srst = 1'b0;
      repeat (5) @(posedge clk_sys);
      ctrl_u.reset_tap();
      for (int r = 0; r < 8; r++)
      begin
         set_io({rows[r].code, 4'h9}, {4'h6, rows[r].code},
                {~rows[r].code, rows[r].code});
         ctrl_u.load_ir(rows[r].code);
         ctrl_u.scan_dr(32, DIN, dout);
         case (rows[r].sel)
            DR_BYP: exp_v = {DIN[30:0], 1'b0};
            DR_ID: exp_v = ID_WORD;
            default: exp_v = {DIN[7:0], core_oe, core_out, pin_in};
         endcase
         check(dout, exp_v, "dr scan");
         repeat (2) @(posedge clk_sys);
         check(ext_mode, rows[r].ext, "ext mode");
         check(core_in, pin_in, "core in");
         if (rows[r].ext)
            check({pin_oe, pin_out}, DIN[31:16], "test pins");
         else if (rows[r].hiz)
            check(pin_oe, 8'h00, "floating");
         else
            check({pin_oe, pin_out}, {core_oe, core_out}, "func");
         $display("test code %h done", rows[r].code);
      end

      // preload kept across the instruction change
      ctrl_u.load_ir(OP_SAMPLE);
      ctrl_u.scan_dr(24, PRE, dout);
      ctrl_u.load_ir(OP_EXTEST);
      set_io(8'hF0, 8'h0F, 8'h33);
      repeat (3) @(posedge clk_sys);
      check({pin_oe, pin_out}, PRE[23:8], "preload");
      ctrl_u.load_ir(OP_HIGHZ);
      repeat (2) @(posedge clk_sys);
      check({ext_mode, pin_oe}, 9'h000, "highz");
      $display("test preload done");

      // three ways back to the identification register
      for (int k = 0; k < 3; k++)
      begin
         ctrl_u.load_ir(OP_EXTEST);
         case (k)
            0: ctrl_u.reset_tap();
            1: ctrl_u.pulse_trst();
            default:
            begin
               @(posedge clk_sys);
               #1 srst = 1'b1;
               repeat (3) @(posedge clk_sys);
               check({tdo_oe, ext_mode, pin_oe}, 10'h000, "srst");
               repeat (7) @(posedge clk_sys);
               #1 srst = 1'b0;
               repeat (5) @(posedge clk_sys);
               ctrl_u.reset_tap();
            end
         endcase
         repeat (2) @(posedge clk_sys);
         check(ext_mode, 1'b0, "ext after reset");
         ctrl_u.scan_dr(32, DIN, dout);
         check(dout, ID_WORD, "id after reset");
         $display("test reset path %0d done", k);
      end
      end_sim();
   end
endmodule // jtag_instruction_decode_tb
`default_nettype wire
